/* common/tpas_defines.vh */
// Purpose: constants for the touch panel sequencer
// Assumes: 125 MHz system clock
// Notes:   channel, resolution and mode codes
`ifndef TPAS_DEFINES_VH
`define TPAS_DEFINES_VH

// ==========================================================
// channel codes
`define TPAS_CH_X        4'h0
`define TPAS_CH_Y        4'h1
`define TPAS_CH_PRS_FIRST  4'h2
`define TPAS_CH_PRS_SECOND 4'h3
`define TPAS_CH_BAT1     4'h4
`define TPAS_CH_BAT2     4'h5
`define TPAS_CH_TEMP     4'h6
`define TPAS_CH_AUX1     4'h7
`define TPAS_CH_AUX2     4'h8
`define TPAS_CH_SCAN     4'hF
`define TPAS_NUM_RES     9

// ==========================================================
// conversion start modes
`define TPAS_MODE_AUTO   2'h0
`define TPAS_MODE_HOSTGO 2'h1
`define TPAS_MODE_HOST   2'h2

// ==========================================================
// resolution codes
`define TPAS_RES_8       2'h0
`define TPAS_RES_10      2'h1
`define TPAS_RES_12      2'h2

// ==========================================================
// driver bit positions: {xp_vdd, xm_gnd, yp_vdd, ym_gnd}
`define TPAS_DRV_X       4'hC
`define TPAS_DRV_Y       4'h3
`define TPAS_DRV_PRS_FIRST  4'h9
`define TPAS_DRV_PRS_SECOND 4'h9
`define TPAS_DRV_IDLE    4'h1
`define TPAS_DRV_OFF     4'h0

// ==========================================================
// mux sense inputs
`define TPAS_SENSE_XP    4'h0
`define TPAS_SENSE_YP    4'h1
`define TPAS_SENSE_XM    4'h2

// ==========================================================
// timing: break counter load, drivers stay off three cycles
`define TPAS_BREAK_CYC   4'h2
`define TPAS_RESULT_RST  16'h0000
`endif

/* src/tpas_seq.v */
// Purpose: four-wire resistive touch panel converter sequencer
// Assumes: host protocol decoded elsewhere into plain control ports
// Notes:   converter is an external SAR driven by start/done handshake
// ==========================================================
// Summary of operation
// R01: host holds select low and clocks
// R02: registers are sixteen bits wide
// R03: results readable any time, no handshake
// R04: done output asserts after conversion completes
// R05: key event only for unmasked debounced key
// R06: touch event whenever panel touched while the sequencer is not busy
// R07: Y sample senses X plus, drives Y
// R08: X sample drives X plates, senses Y
// R09: first and second pressure samples supported
// R10: programmable settle delay before conversion; the code skips it in host mode and after a drivers-on command
// R11: drivers-on command without converting
// R12: three conversion start modes
// R13: input mux selects conversion source
// R14: control settings steer converter mode
// R15: result stored per measured quantity
// R16: done low until host reads new data
// R17: key event active low
// R18: touch event low while panel touched; held at its last value while busy
// R19: resolution eight, ten or twelve bits
// R20: drivers off before new driver set
`timescale 1ns/1ns
`include "tpas_defines.vh"

module tpas_seq #(
    parameter DW = 16, // R02
    parameter DLY_W = 16
) (
    // clock and reset
    input  wire             i_clk_sys,
    input  wire             i_rst,
    // control from host register port
    input  wire [3:0]       i_channel,
    input  wire [1:0]       i_mode,
    input  wire [1:0]       i_resolution,
    input  wire [2:0]       i_avg_log2,
    input  wire [2:0]       i_clk_div,
    input  wire [DLY_W-1:0] i_settle_cycles,
    input  wire             i_start,
    input  wire             i_drivers_only,
    input  wire [3:0]       i_rd_sel,
    input  wire             i_rd_strobe,
    // panel and key status pins
    input  wire             i_touch_pin_n,
    input  wire             i_key_valid,
    input  wire             i_key_masked,
    // converter handshake
    input  wire             i_adc_done,
    input  wire [11:0]      i_adc_data,
    output reg              o_adc_start,
    output reg  [1:0]       o_adc_res,
    output reg  [2:0]       o_adc_div,
    output reg  [3:0]       o_adc_mux,
    output reg  [3:0]       o_drv,
    // results and events
    output reg  [DW-1:0]    o_rd_data,
    output reg              o_conversion_done_n,
    output reg              o_key_event_n,
    output reg              o_touch_event_n,
    output reg              o_busy
);

    // ==========================================================
    // state codes
    localparam S_IDLE   = 3'h0;
    localparam S_BREAK  = 3'h1;
    localparam S_SETTLE = 3'h2;
    localparam S_CONV   = 3'h3;
    localparam S_WAIT   = 3'h4;
    localparam S_HOLD   = 3'h5;

    reg [2:0]       state_q;
    reg [3:0]       cur_ch_q;
    reg [3:0]       brk_q;
    reg [DLY_W-1:0] dly_q;
    reg [7:0]       avg_cnt_q;
    reg [15:0]      acc_q;
    reg [DW-1:0]    res_q [0:`TPAS_NUM_RES-1];
    reg [`TPAS_NUM_RES-1:0] new_q;
    reg             scan_q;
    reg             drv_only_q;
    reg             t_m_q, t_s_q, k_m_q, k_s_q, mk_m_q, mk_s_q;
    integer         i;

    // ==========================================================
    // driver pattern per channel
    function [3:0] drv_of;
        input [3:0] ch;
        begin
            case (ch)
                `TPAS_CH_X:  drv_of = `TPAS_DRV_X;  // R08
                `TPAS_CH_Y:  drv_of = `TPAS_DRV_Y;  // R07
                `TPAS_CH_PRS_FIRST:  drv_of = `TPAS_DRV_PRS_FIRST;  // R09
                `TPAS_CH_PRS_SECOND: drv_of = `TPAS_DRV_PRS_SECOND; // R09
                default:     drv_of = `TPAS_DRV_OFF;
            endcase
        end
    endfunction

    // mux code: panel channels map to the sensed plate
    function [3:0] mux_of;
        input [3:0] ch;
        begin
            case (ch)
                `TPAS_CH_X:  mux_of = `TPAS_SENSE_YP;
                `TPAS_CH_Y:  mux_of = `TPAS_SENSE_XP; // R07
                `TPAS_CH_PRS_FIRST:  mux_of = `TPAS_SENSE_XP;
                `TPAS_CH_PRS_SECOND: mux_of = `TPAS_SENSE_XM;
                default:     mux_of = ch;             // R13
            endcase
        end
    endfunction

    // result justified to resolution
    function [11:0] trim;
        input [11:0] d;
        input [1:0]  r;
        begin
            case (r)
                `TPAS_RES_8:  trim = {4'h0, d[11:4]};
                `TPAS_RES_10: trim = {2'h0, d[11:2]};
                default:      trim = d;
            endcase
        end
    endfunction

    wire touched  = ~t_s_q;
    wire [15:0] acc_n = acc_q + {4'h0, trim(i_adc_data, o_adc_res)};
    wire last_avg = (avg_cnt_q == ((8'h01 << i_avg_log2) - 8'h01));
    wire [3:0] first_ch = (i_channel == `TPAS_CH_SCAN) ? `TPAS_CH_X : i_channel;
    wire auto_go = (i_mode == `TPAS_MODE_AUTO) && touched;        // R12
    wire host_go = i_start && ((i_mode != `TPAS_MODE_HOSTGO) || touched); // R12
    wire rd_clr  = i_rd_strobe && (i_rd_sel < `TPAS_NUM_RES);

    // ==========================================================
    // pin synchronisers
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            t_m_q  <= 1'b1;
            t_s_q  <= 1'b1;
            k_m_q  <= 1'b0;
            k_s_q  <= 1'b0;
            mk_m_q <= 1'b1;
            mk_s_q <= 1'b1;
        end else begin
            t_m_q  <= i_touch_pin_n;
            t_s_q  <= t_m_q;
            k_m_q  <= i_key_valid;
            k_s_q  <= k_m_q;
            mk_m_q <= i_key_masked;
            mk_s_q <= mk_m_q;
        end
    end

    // ==========================================================
    // sequencer
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q     <= S_IDLE;
            cur_ch_q    <= 4'h0;
            brk_q       <= 4'h0;
            dly_q       <= {DLY_W{1'b0}};
            avg_cnt_q   <= 8'h00;
            acc_q       <= 16'h0000;
            scan_q      <= 1'b0;
            drv_only_q  <= 1'b0;
            o_adc_start <= 1'b0;
            o_adc_res   <= `TPAS_RES_12;
            o_adc_div   <= 3'h0;
            o_adc_mux   <= 4'h0;
            o_drv       <= `TPAS_DRV_IDLE;
            o_busy      <= 1'b0;
            new_q       <= {`TPAS_NUM_RES{1'b0}};
            for (i = 0; i < `TPAS_NUM_RES; i = i + 1) begin
                res_q[i] <= `TPAS_RESULT_RST;
            end
        end else begin
            o_adc_start <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    o_busy <= 1'b0;
                    if (auto_go || host_go || i_drivers_only) begin
                        cur_ch_q   <= first_ch;
                        scan_q     <= (i_channel == `TPAS_CH_SCAN);
                        drv_only_q <= i_drivers_only;               // R11
                        o_adc_res  <= (i_resolution > `TPAS_RES_12) ? `TPAS_RES_12 : i_resolution; // R14 R19
                        o_adc_div  <= i_clk_div;                    // R14
                        o_drv      <= `TPAS_DRV_OFF;                // R20
                        brk_q      <= `TPAS_BREAK_CYC;
                        o_busy     <= 1'b1;
                        state_q    <= S_BREAK;
                    end
                end
                S_BREAK: begin
                    if (brk_q == 4'h0) begin
                        o_drv     <= drv_of(cur_ch_q);
                        o_adc_mux <= mux_of(cur_ch_q);              // R13
                        dly_q     <= i_settle_cycles;
                        avg_cnt_q <= 8'h00;
                        acc_q     <= 16'h0000;
                        // host-controlled mode times settling itself
                        state_q   <= drv_only_q ? S_HOLD :
                                     (i_mode == `TPAS_MODE_HOST) ? S_CONV : S_SETTLE;
                    end else begin
                        brk_q <= brk_q - 4'h1;
                    end
                end
                S_SETTLE: begin
                    if (dly_q == {DLY_W{1'b0}}) begin
                        state_q <= S_CONV;                          // R10
                    end else begin
                        dly_q <= dly_q - {{(DLY_W-1){1'b0}}, 1'b1};
                    end
                end
                S_CONV: begin
                    o_adc_start <= 1'b1;
                    state_q     <= S_WAIT;
                end
                S_WAIT: begin
                    if (i_adc_done) begin
                        acc_q <= acc_n;
                        if (last_avg) begin
                            res_q[cur_ch_q] <= {{(DW-12){1'b0}}, acc_n[11+i_avg_log2 -: 12]}; // R15
                            new_q[cur_ch_q] <= 1'b1;                // R15
                            if (scan_q && cur_ch_q < `TPAS_CH_PRS_SECOND) begin
                                cur_ch_q <= cur_ch_q + 4'h1;
                                o_drv    <= `TPAS_DRV_OFF;          // R20
                                brk_q    <= `TPAS_BREAK_CYC;
                                state_q  <= S_BREAK;
                            end else begin
                                o_drv   <= `TPAS_DRV_IDLE;          // R18
                                state_q <= S_IDLE;
                            end
                        end else begin
                            avg_cnt_q <= avg_cnt_q + 8'h01;
                            state_q   <= S_CONV;
                        end
                    end
                end
                S_HOLD: begin
                    // drivers stay on until the host asks to convert
                    if (i_start) begin
                        state_q <= S_CONV;                          // R11
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            // read clears fresh flag; a same-cycle write wins
            if (rd_clr && !(state_q == S_WAIT && i_adc_done && last_avg && cur_ch_q == i_rd_sel)) begin
                new_q[i_rd_sel] <= 1'b0;                            // R16
            end
        end
    end

    // ==========================================================
    // host read port and event outputs
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rd_data           <= {DW{1'b0}};
            o_conversion_done_n <= 1'b1;
            o_key_event_n       <= 1'b1;
            o_touch_event_n     <= 1'b1;
        end else begin
            o_rd_data           <= (i_rd_sel < `TPAS_NUM_RES) ? res_q[i_rd_sel] : {DW{1'b0}}; // R03
            o_conversion_done_n <= ~(|new_q);                      // R04 R16
            o_key_event_n       <= ~(k_s_q && !mk_s_q);            // R05 R17
            // pen sense is disconnected while measuring
            o_touch_event_n     <= o_busy ? o_touch_event_n : ~touched; // R06 R18
        end
    end

endmodule

/* verification/tpas_panel_model.sv */
// Purpose: panel and converter seen from the sequencer
// Assumes: converter answers with a one-cycle done pulse
// Notes:   code = {drivers, mux, A}; alternates fast and slow answers
`timescale 1ns/1ns
`include "tpas_defines.vh"
module tpas_panel_model (
    input  wire        i_clk_sys,
    input  wire        i_adc_start,
    input  wire [3:0]  i_adc_mux,
    input  wire [3:0]  i_drv,
    input  wire        i_touched,
    output reg         o_adc_done,
    output reg  [11:0] o_adc_data,
    output wire        o_touch_pin_n
);
    reg [5:0]  cnt_q = 6'h00;
    reg        slow_q = 1'b0;
    reg [11:0] code_q = 12'h000;
    initial begin
        o_adc_done = 1'b0;
        o_adc_data = 12'h000;
    end
    // x plus only sees the pull-up path while monitor drivers are on
    assign o_touch_pin_n = !(i_touched && i_drv == `TPAS_DRV_IDLE);
    always @(posedge i_clk_sys) begin
        o_adc_done <= 1'b0;
        // data is not held outside the done pulse
        o_adc_data <= ~o_adc_data;
        if (i_adc_start) begin
            cnt_q  <= slow_q ? 6'h14 : 6'h02;
            slow_q <= ~slow_q;
            code_q <= {i_drv, i_adc_mux, 4'hA};
        end else if (cnt_q == 6'h01) begin
            o_adc_done <= 1'b1;
            o_adc_data <= code_q;
            cnt_q      <= 6'h00;
        end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
        end
    end
endmodule

/* verification/tpas_seq_bench.sv */
// Purpose: self-checking bench for the touch panel sequencer
// Assumes: host conversions unless a test switches mode
// Notes:   averaging off unless a test enables it, so each sample lands unaltered
`timescale 1ns/1ns
`include "tpas_defines.vh"
module tpas_seq_bench;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  channel = 4'h0;
    reg  [1:0]  mode = `TPAS_MODE_HOST;
    reg  [1:0]  resolution = `TPAS_RES_12;
    reg         start = 1'b0;
    reg         drv_only = 1'b0;
    reg  [3:0]  rd_sel = 4'h0;
    reg         rd_strobe = 1'b0;
    reg         touched = 1'b0;
    reg         key_valid = 1'b0;
    reg         key_masked = 1'b0;
    reg  [2:0]  avg = 3'h0;
    wire        adc_done, touch_n, adc_start, done_n, key_n, tev_n, busy;
    wire [1:0]  adc_res;
    wire [2:0]  adc_div;
    wire [11:0] adc_data;
    wire [3:0]  adc_mux, drv;
    wire [15:0] rd_data;
    integer     fails = 0;
    integer     n_compared = 0;
    integer     cycles = 0;
    always #4 clk_sys = ~clk_sys;
    tpas_seq dut (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_channel(channel), .i_mode(mode), .i_resolution(resolution),
        .i_avg_log2(avg), .i_clk_div(3'h2), .i_settle_cycles(16'h0005), .i_start(start),
        .i_drivers_only(drv_only), .i_rd_sel(rd_sel), .i_rd_strobe(rd_strobe), .i_touch_pin_n(touch_n),
        .i_key_valid(key_valid), .i_key_masked(key_masked), .i_adc_done(adc_done), .i_adc_data(adc_data),
        .o_adc_start(adc_start), .o_adc_res(adc_res), .o_adc_div(adc_div), .o_adc_mux(adc_mux), .o_drv(drv),
        .o_rd_data(rd_data), .o_conversion_done_n(done_n), .o_key_event_n(key_n),
        .o_touch_event_n(tev_n), .o_busy(busy)
    );
    tpas_panel_model u_panel (
        .i_clk_sys(clk_sys), .i_adc_start(adc_start), .i_adc_mux(adc_mux), .i_drv(drv),
        .i_touched(touched), .o_adc_done(adc_done), .o_adc_data(adc_data), .o_touch_pin_n(touch_n)
    );
    // ==========================================================
    // tasks
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task check(input [15:0] got, input [15:0] exp, input [15:0] mask);
        begin
            n_compared = n_compared + 1;
            if ((got & mask) !== (exp & mask)) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task pulse_start;
        begin
            @(posedge clk_sys);
            start <= 1'b1;
            @(posedge clk_sys);
            start <= 1'b0;
        end
    endtask
    // waits for new data, then for the sequence to go idle
    task wait_done;
        integer i;
        begin
            for (i = 0; i < 400 && (done_n !== 1'b0 || busy !== 1'b0); i = i + 1) begin
                @(posedge clk_sys);
            end
            #1;
        end
    endtask
    task rd(input [3:0] sel, input [15:0] exp, input [15:0] mask);
        begin
            @(posedge clk_sys);
            rd_sel    <= sel;
            rd_strobe <= 1'b1;
            @(posedge clk_sys);
            rd_strobe <= 1'b0;
            #1 check(rd_data, exp, mask);
        end
    endtask
    task conv(input [3:0] ch, input [15:0] exp, input [15:0] mask);
        begin
            @(posedge clk_sys);
            channel <= ch;
            pulse_start;
            wait_done;
            rd(ch, exp, mask);
        end
    endtask
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            final_report;
        end
    end
    // ==========================================================
    // tests
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1 check({8'h00, drv, done_n, key_n, tev_n, busy}, 16'h001E, 16'h00FF);
        conv(4'h0, 16'h0C1A, 16'hFFFF);
        conv(4'h1, 16'h030A, 16'hFFFF);
        conv(4'h2, 16'h090A, 16'hFF0F);
        conv(4'h3, 16'h090A, 16'hFF0F);
        resolution <= `TPAS_RES_8;
        conv(4'h0, 16'h00C1, 16'hFFFF);
        check({11'h000, adc_res, adc_div}, 16'h0002, 16'hFFFF);
        resolution <= `TPAS_RES_10;
        conv(4'h1, 16'h00C2, 16'hFFFF);
        resolution <= `TPAS_RES_12;
        @(posedge clk_sys);
        channel <= 4'hF;
        pulse_start;
        wait_done;
        rd(4'h0, 16'h0C1A, 16'hFFFF);
        rd(4'h1, 16'h030A, 16'hFFFF);
        rd(4'h2, 16'h090A, 16'hFF0F);
        check({15'h0, done_n}, 16'h0000, 16'hFFFF);
        rd(4'h3, 16'h090A, 16'hFF0F);
        repeat (2) @(posedge clk_sys);
        #1 check({15'h0, done_n}, 16'h0001, 16'hFFFF);
        mode <= `TPAS_MODE_HOSTGO;
        pulse_start;
        repeat (4) @(posedge clk_sys);
        #1 check({15'h0, busy}, 16'h0000, 16'hFFFF);
        touched <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 check({15'h0, tev_n}, 16'h0000, 16'hFFFF);
        conv(4'h0, 16'h0C1A, 16'hFFFF);
        mode <= `TPAS_MODE_AUTO;
        wait_done;
        touched <= 1'b0;
        mode    <= `TPAS_MODE_HOST;
        repeat (3) @(posedge clk_sys);
        wait_done;
        rd(4'h0, 16'h0C1A, 16'hFFFF);
        channel  <= 4'h1;
        drv_only <= 1'b1;
        @(posedge clk_sys);
        drv_only <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 check({8'h00, drv, 3'h0, done_n}, 16'h0031, 16'h00FF);
        pulse_start;
        wait_done;
        rd(4'h1, 16'h030A, 16'hFFFF);
        // two samples summed, upper twelve bits kept
        avg <= 3'h1;
        conv(4'h1, 16'h030A, 16'hFFFF);
        avg <= 3'h0;
        key_valid  <= 1'b1;
        key_masked <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 check({15'h0, key_n}, 16'h0001, 16'hFFFF);
        key_masked <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 check({15'h0, key_n}, 16'h0000, 16'hFFFF);
        key_valid <= 1'b0;
        rd(4'h9, 16'h0000, 16'hFFFF);
        final_report;
    end
endmodule

/* verification/tpas_seq_properties.sv */
// Purpose: port properties of the touch panel sequencer
// Assumes: one clock, synchronous active high reset
// Notes:   bound onto every tpas_seq instance
`timescale 1ns/1ns
`include "tpas_defines.vh"
module tpas_seq_properties (
    input wire       i_clk_sys,
    input wire       i_rst,
    input wire       i_key_valid,
    input wire       i_key_masked,
    input wire       i_touch_pin_n,
    input wire       i_adc_done,
    input wire       o_adc_start,
    input wire [3:0] o_adc_mux,
    input wire [3:0] o_drv,
    input wire       o_conversion_done_n,
    input wire       o_key_event_n,
    input wire       o_touch_event_n,
    input wire       o_busy
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // ==========================================================
    // driver switching
    chk_drv_break: assert property (($past(o_drv) > 4'h1) && (o_drv > 4'h1) |-> o_drv == $past(o_drv))
        else $error("two driver sets without break");
    chk_break_len: assert property ($rose(o_busy) |-> (o_drv == 4'h0)[*3] ##1 (o_drv != 4'h0 || o_adc_mux > `TPAS_SENSE_XM))
        else $error("break length wrong");
    chk_mux_y: assert property (o_adc_start && o_drv == `TPAS_DRV_Y |-> o_adc_mux == `TPAS_SENSE_XP)
        else $error("y sample senses wrong plate");
    chk_mux_x: assert property (o_adc_start && o_drv == `TPAS_DRV_X |-> o_adc_mux == `TPAS_SENSE_YP)
        else $error("x sample senses wrong plate");
    // ==========================================================
    // converter and events
    chk_start_pulse: assert property (o_adc_start |-> o_busy ##1 !o_adc_start)
        else $error("start not a single pulse");
    chk_done_flag: assert property (i_adc_done |-> ##[1:2] (!o_conversion_done_n || o_adc_start))
        else $error("done output missing");
    chk_key_on: assert property ((i_key_valid && !i_key_masked)[*5] |-> !o_key_event_n)
        else $error("key event missing");
    chk_key_off: assert property ((!i_key_valid)[*5] |-> o_key_event_n)
        else $error("key event without key");
    chk_touch_on: assert property ((!i_touch_pin_n && !o_busy)[*5] |-> !o_touch_event_n)
        else $error("touch event missing");
endmodule

bind tpas_seq tpas_seq_properties u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_key_valid(i_key_valid), .i_key_masked(i_key_masked),
    .i_touch_pin_n(i_touch_pin_n), .i_adc_done(i_adc_done), .o_adc_start(o_adc_start),
    .o_adc_mux(o_adc_mux), .o_drv(o_drv), .o_conversion_done_n(o_conversion_done_n),
    .o_key_event_n(o_key_event_n), .o_touch_event_n(o_touch_event_n), .o_busy(o_busy)
);
